/* common/drive_regs_pkg.sv */
// shared constants, types and helpers for the drive parameter register bank
`default_nettype none
package drive_regs_pkg;

  // word layout on the link: four hex characters per 16-bit word
  localparam int WORD_W    = 16;
  localparam int HEX_CHARS = 4;

  // common-area addresses, identical on every drive model
  localparam logic [15:0] ADDR_MODEL   = 16'h0000;
  localparam logic [15:0] ADDR_RATING  = 16'h0001;
  localparam logic [15:0] ADDR_VCLASS  = 16'h0002;
  localparam logic [15:0] ADDR_VERSION = 16'h0003;
  localparam logic [15:0] ADDR_TFREQ   = 16'h0005;
  localparam logic [15:0] ADDR_CMD     = 16'h0006;
  localparam logic [15:0] ADDR_RUP     = 16'h0007;
  localparam logic [15:0] ADDR_RDN     = 16'h0008;
  localparam logic [15:0] ADDR_CURR    = 16'h0009;
  localparam logic [15:0] ADDR_OFREQ   = 16'h000A;
  localparam logic [15:0] ADDR_OVOLT   = 16'h000B;
  localparam logic [15:0] ADDR_BUSV    = 16'h000C;
  localparam logic [15:0] ADDR_OPWR    = 16'h000D;
  localparam logic [15:0] ADDR_STATE   = 16'h000E;

  // command word fields
  localparam int CMD_STOP_BIT  = 0;
  localparam int CMD_FWD_BIT   = 1;
  localparam int CMD_REV_BIT   = 2;
  localparam int CMD_FRST_BIT  = 3;
  localparam int CMD_ESTOP_BIT = 4;
  localparam int CMD_SRC_LSB   = 6;
  localparam int CMD_SRC_W     = 2;
  localparam int CMD_FSRC_LSB  = 8;
  localparam int CMD_FSRC_W    = 5;
  localparam int CMD_NETERR_BIT = 15;
  localparam logic [15:0] CMD_WR_MASK = 16'h1FDF;
  localparam logic [4:0]  FSRC_RSVD_A = 5'h14;
  localparam logic [4:0]  FSRC_RSVD_B = 5'h15;

  // operating status flags
  localparam int STATE_STOP_BIT  = 0;
  localparam int STATE_FWD_BIT   = 1;
  localparam int STATE_REV_BIT   = 2;
  localparam int STATE_TRIP_BIT  = 3;
  localparam int STATE_ACCEL_BIT = 4;
  localparam int STATE_DECEL_BIT = 5;
  localparam logic [15:0] STATE_MASK = 16'h003F;

  // valid rating codes
  localparam logic [15:0] RATING_MIN = 16'h0004;
  localparam logic [15:0] RATING_MAX = 16'h0017;

  // measurement scaling: one count in each unit
  localparam int FREQ_STEP_MHZ = 10;
  localparam int CURR_STEP_MA  = 100;
  localparam int VOLT_STEP_MV  = 100;

  localparam logic [15:0] RESET_WORD = 16'h0000;

  // answer to each access
  typedef enum logic [1:0] {
    RSP_OK            = 2'h0,
    RSP_BAD_ADDR      = 2'h1,
    RSP_BAD_VALUE     = 2'h2,
    RSP_WRITE_REFUSED = 2'h3
  } rsp_status_type;

  // bank controller states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_COLLECT = 3'h2,
    ST_SEND    = 3'h4
  } bank_state_type;

  // one nibble to its upper-case ascii hex character
  function automatic logic [7:0] nib_to_ascii(input logic [3:0] n);
    nib_to_ascii = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

endpackage
`default_nettype wire

/* rtl/hex_word_codec.sv */
// ascii hex character codec for one link word in each direction
`timescale 1ns/1ps
`default_nettype none
module hex_word_codec
  import drive_regs_pkg::*;
#(
  parameter int NIBBLES = HEX_CHARS
)
(
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic [7:0]             rx_char,
  input  wire logic                   rx_valid,
  output logic      [4*NIBBLES-1:0]   rx_word,
  output logic                        rx_done,
  output logic                        rx_bad,
  input  wire logic                   tx_start,
  input  wire logic [4*NIBBLES-1:0]   tx_word,
  output logic      [7:0]             tx_char,
  output logic                        tx_valid,
  output logic                        tx_busy
);

  localparam int CW = (NIBBLES > 1) ? $clog2(NIBBLES) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(NIBBLES - 1);

  // refuse widths the counters cannot serve
  if (NIBBLES < 2 || NIBBLES > 8)
  begin : g_nib_check
    $error("hex_word_codec: NIBBLES must lie in 2..8");
  end

  // bit 4 set marks a character that is not hex
  function automatic logic [4:0] ascii_to_nib(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39)
      ascii_to_nib = {1'b0, c[3:0]};
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
      ascii_to_nib = {1'b0, c[3:0] + 4'h9};
    else
      ascii_to_nib = 5'h10;
  endfunction

  logic [CW-1:0]          rx_cnt_reg;
  logic [4*NIBBLES-1:0]   rx_acc_reg;
  logic [CW-1:0]          tx_left_reg;
  logic [4*NIBBLES-1:0]   tx_shift_reg;

  wire  [4:0]             rx_nib  = ascii_to_nib(rx_char);
  wire  [4*NIBBLES-1:0]   rx_next = {rx_acc_reg[4*NIBBLES-5:0], rx_nib[3:0]};
  wire                    rx_last = rx_valid && !rx_nib[4] && rx_cnt_reg == CNT_LAST;

  assign tx_busy = tx_left_reg != '0;

  // decode: most significant digit arrives first; a bad character restarts the word
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      rx_cnt_reg <= '0;
      rx_acc_reg <= '0;
      rx_word    <= '0;
      rx_done    <= 1'b0;
      rx_bad     <= 1'b0;
    end
    else
    begin
      rx_done <= rx_last;
      rx_bad  <= rx_valid && rx_nib[4];
      if (rx_valid && rx_nib[4])
        rx_cnt_reg <= '0;
      else if (rx_valid)
      begin
        rx_acc_reg <= rx_next;
        rx_cnt_reg <= rx_last ? '0 : rx_cnt_reg + 1'b1;
      end
      if (rx_last)
        rx_word <= rx_next;
    end
  end

  // encode: one character per cycle, most significant digit first
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      tx_left_reg  <= '0;
      tx_shift_reg <= '0;
      tx_char      <= 8'h00;
      tx_valid     <= 1'b0;
    end
    else if (tx_start && !tx_busy)
    begin
      tx_char      <= nib_to_ascii(tx_word[4*NIBBLES-1 -: 4]);
      tx_shift_reg <= {tx_word[4*NIBBLES-5:0], 4'h0};
      tx_left_reg  <= CNT_LAST;
      tx_valid     <= 1'b1;
    end
    else if (tx_busy)
    begin
      tx_char      <= nib_to_ascii(tx_shift_reg[4*NIBBLES-1 -: 4]);
      tx_shift_reg <= {tx_shift_reg[4*NIBBLES-5:0], 4'h0};
      tx_left_reg  <= tx_left_reg - 1'b1;
    end
    else
      tx_valid <= 1'b0;
  end

endmodule // hex_word_codec
`default_nettype wire

/* rtl/drive_param_bank.sv */
// common parameter register bank of the drive, reached over the serial link
//
// Notes on behaviour
// (R1) common-area addresses are fixed constants, the same for every model
// (R2) rating is read-only; only codes 4 through 0x17 are accepted from firmware
// (R3) firmware version is a read-only word, 0x0100 meaning version 1.00
// (R4) fault reset pulses only on a 0 to 1 change of command bit 3
// (R5) command bits 0, 1, 2 drive stop, forward run and reverse run
// (R6) command bit 4 requests emergency stop; bit 5 is unused, reads zero
// (R7) command bits 7:6 give the run/stop source: terminal, keypad, option, link
// (R8) command bits 12:8 give the frequency source; codes 20 and 21 are refused
// (R9) command bit 15 is set whenever a network error occurs
// (R10) status word bits 0..5: stop, forward, reverse, trip, accel, decel
// (R11) frequency counts 0.01 Hz, current 0.1 A, voltage 0.1 V
// (R12) writes to read-only or run-locked words answer with a write refusal
// (R13) each word crosses the link as four hex characters, high digit first
// (R14) all words are 16 bits and clear to zero at reset
`timescale 1ns/1ps
`default_nettype none
module drive_param_bank
  import drive_regs_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             cmd_valid,
  input  wire logic             cmd_write,
  input  wire logic [15:0]      cmd_addr,
  output logic                  cmd_ready,
  input  wire logic [7:0]       wr_char,
  input  wire logic             wr_char_valid,
  output logic                  rsp_valid,
  output rsp_status_type        rsp_status,
  output logic      [7:0]       rsp_char,
  output logic                  rsp_char_valid,
  input  wire logic             fw_load,
  input  wire logic [15:0]      fw_addr,
  input  wire logic [15:0]      fw_data,
  input  wire logic             net_error,
  output logic      [15:0]      target_frequency,
  output logic      [15:0]      ramp_up_time,
  output logic      [15:0]      ramp_down_time,
  output logic                  stop_cmd,
  output logic                  fwd_run_cmd,
  output logic                  rev_run_cmd,
  output logic                  fault_reset_pulse,
  output logic                  emergency_stop,
  output logic      [1:0]       run_source,
  output logic      [4:0]       freq_source,
  output logic                  net_error_flag
);

  // the address field is fixed by the link format
  if (ADDR_W != WORD_W)
  begin : g_addr_check
    $error("drive_param_bank: ADDR_W must equal the 16-bit word");
  end

  // (R1) (R3) fixed map of read-only words
  function automatic logic addr_is_ro(input logic [15:0] a);
    addr_is_ro = a inside {ADDR_MODEL, ADDR_RATING, ADDR_VCLASS, ADDR_VERSION,
                           ADDR_CURR, ADDR_OFREQ, ADDR_OVOLT, ADDR_BUSV,
                           ADDR_OPWR, ADDR_STATE};
  endfunction

  // (R1) fixed map of writable words
  function automatic logic addr_is_rw(input logic [15:0] a);
    addr_is_rw = a inside {ADDR_TFREQ, ADDR_CMD, ADDR_RUP, ADDR_RDN};
  endfunction

  bank_state_type   state_reg;
  bank_state_type   state_next;
  logic [15:0]      addr_reg;
  logic [15:0]      ro_mem [0:15];
  logic [15:0]      tfreq_reg;
  logic [15:0]      rup_reg;
  logic [15:0]      rdn_reg;
  logic [15:0]      cmd_bits_reg;
  logic             neterr_reg;
  logic             fault_reg;
  logic             ready_reg;
  logic             rsp_valid_reg;
  rsp_status_type   rsp_status_reg;
  rsp_status_type   wr_status;
  rsp_status_type   rsp_status_next;

  logic [15:0]      rx_word;
  logic             rx_done;
  logic             rx_bad;
  logic             tx_busy;
  logic [7:0]       tx_char;
  logic             tx_valid;

  // request acceptance and read classification
  wire  take_cmd  = cmd_valid && state_reg == ST_IDLE;
  wire  cmd_map   = addr_is_ro(cmd_addr) || addr_is_rw(cmd_addr);
  wire  read_ok   = take_cmd && !cmd_write && cmd_map;
  wire  read_bad  = take_cmd && !cmd_write && !cmd_map;
  wire  collect   = state_reg == ST_COLLECT;
  wire  rx_feed   = wr_char_valid && collect && !rx_done;

  // status flags that gate the run lock
  wire  [15:0] state_word = ro_mem[ADDR_STATE[3:0]];
  wire  running = state_word[STATE_FWD_BIT] || state_word[STATE_REV_BIT];

  // (R6) bit 5 and bits 14:13 always read back as zero
  wire  [15:0] cmd_readback = cmd_bits_reg | {neterr_reg, 15'h0000};

  // read selection; words outside the map read as zero
  wire  [15:0] rd_word = (cmd_addr == ADDR_TFREQ) ? tfreq_reg :
                         (cmd_addr == ADDR_CMD)   ? cmd_readback :
                         (cmd_addr == ADDR_RUP)   ? rup_reg :
                         (cmd_addr == ADDR_RDN)   ? rdn_reg :
                         addr_is_ro(cmd_addr)     ? ro_mem[cmd_addr[3:0]] :
                                                    RESET_WORD;

  // write classification once the fourth character has been decoded
  wire  wr_map    = addr_is_ro(addr_reg) || addr_is_rw(addr_reg);
  wire  ramp_addr = addr_reg == ADDR_RUP || addr_reg == ADDR_RDN;
  wire  [4:0] wr_fsrc = rx_word[CMD_FSRC_LSB +: CMD_FSRC_W];
  wire  fsrc_rsvd = wr_fsrc == FSRC_RSVD_A || wr_fsrc == FSRC_RSVD_B;

  // (R12) read-only words and ramp times during run refuse the write
  // (R8) reserved frequency sources are an illegal value
  assign wr_status = !wr_map                          ? RSP_BAD_ADDR :
                     addr_is_ro(addr_reg)             ? RSP_WRITE_REFUSED :
                     (ramp_addr && running)           ? RSP_WRITE_REFUSED :
                     (addr_reg == ADDR_CMD && fsrc_rsvd) ? RSP_BAD_VALUE :
                                                         RSP_OK;

  wire  wr_commit  = rx_done && collect && wr_status == RSP_OK;
  wire  cmd_commit = wr_commit && addr_reg == ADDR_CMD;

  // (R4) only a rising fault-reset bit makes a pulse
  wire  fault_next = cmd_commit && rx_word[CMD_FRST_BIT] && !cmd_bits_reg[CMD_FRST_BIT];

  // (R9) a new error wins over a clearing write in the same cycle
  wire  neterr_next = net_error ||
                      (neterr_reg && !(cmd_commit && !rx_word[CMD_NETERR_BIT]));

  // answer selection for every kind of access
  wire  rsp_valid_next = read_ok || read_bad || (collect && (rx_done || rx_bad));
  assign rsp_status_next = read_bad ? RSP_BAD_ADDR :
                           rx_bad   ? RSP_BAD_VALUE :
                           rx_done  ? wr_status :
                                      RSP_OK;

  // firmware loading of the read-only words
  wire  fw_ro     = fw_load && addr_is_ro(fw_addr);
  // (R2) rating codes outside the valid range are dropped
  wire  rating_ok = fw_addr != ADDR_RATING ||
                    (fw_data >= RATING_MIN && fw_data <= RATING_MAX);
  // (R10) only the six status flags are kept
  wire  [15:0] fw_word = (fw_addr == ADDR_STATE) ? (fw_data & STATE_MASK) : fw_data;

  // controller sequencing
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (read_ok)
          state_next = ST_SEND;
        else if (take_cmd && cmd_write)
          state_next = ST_COLLECT;
      end
      ST_COLLECT:
      begin
        if (rx_done || rx_bad)
          state_next = ST_IDLE;
      end
      ST_SEND:
      begin
        if (!tx_busy)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  // (R13) link words pass through the hex codec
  hex_word_codec #(
    .NIBBLES (HEX_CHARS)
  ) u_codec (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .rx_char  (wr_char),
    .rx_valid (rx_feed),
    .rx_word  (rx_word),
    .rx_done  (rx_done),
    .rx_bad   (rx_bad),
    .tx_start (read_ok),
    .tx_word  (rd_word),
    .tx_char  (tx_char),
    .tx_valid (tx_valid),
    .tx_busy  (tx_busy)
  );

  // control state and answers
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state_reg      <= ST_IDLE;
      addr_reg       <= RESET_WORD;
      ready_reg      <= 1'b1;
      rsp_valid_reg  <= 1'b0;
      rsp_status_reg <= RSP_OK;
      fault_reg      <= 1'b0;
      neterr_reg     <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      ready_reg      <= state_next == ST_IDLE;
      rsp_valid_reg  <= rsp_valid_next;
      rsp_status_reg <= rsp_status_next;
      fault_reg      <= fault_next;
      neterr_reg     <= neterr_next;
      if (take_cmd)
        addr_reg <= cmd_addr;
    end
  end

  // (R14) writable words clear at reset and change only on an accepted write
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      tfreq_reg    <= RESET_WORD;
      rup_reg      <= RESET_WORD;
      rdn_reg      <= RESET_WORD;
      cmd_bits_reg <= RESET_WORD;
    end
    else if (wr_commit)
    begin
      if (addr_reg == ADDR_TFREQ)
        tfreq_reg <= rx_word;
      if (addr_reg == ADDR_RUP)
        rup_reg <= rx_word;
      if (addr_reg == ADDR_RDN)
        rdn_reg <= rx_word;
      if (cmd_commit)
        cmd_bits_reg <= rx_word & CMD_WR_MASK;
    end
  end

  // (R14) read-only words clear at reset until firmware loads them
  // (R11) values arrive already scaled in link counts
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 16; i++)
        ro_mem[i] <= RESET_WORD;
    end
    else if (fw_ro && rating_ok)
      ro_mem[fw_addr[3:0]] <= fw_word;
  end

  // outputs taken straight from their flip-flops
  // (R5) run commands from the command word
  assign stop_cmd          = cmd_bits_reg[CMD_STOP_BIT];
  assign fwd_run_cmd       = cmd_bits_reg[CMD_FWD_BIT];
  assign rev_run_cmd       = cmd_bits_reg[CMD_REV_BIT];
  // (R6) emergency stop request
  assign emergency_stop    = cmd_bits_reg[CMD_ESTOP_BIT];
  // (R7) run/stop command source field
  assign run_source        = cmd_bits_reg[CMD_SRC_LSB +: CMD_SRC_W];
  assign freq_source       = cmd_bits_reg[CMD_FSRC_LSB +: CMD_FSRC_W];
  assign fault_reset_pulse = fault_reg;
  assign net_error_flag    = neterr_reg;
  assign target_frequency  = tfreq_reg;
  assign ramp_up_time      = rup_reg;
  assign ramp_down_time    = rdn_reg;
  assign cmd_ready         = ready_reg;
  assign rsp_valid         = rsp_valid_reg;
  assign rsp_status        = rsp_status_reg;
  assign rsp_char          = tx_char;
  assign rsp_char_valid    = tx_valid;

  // checks on the bank behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // (R4) rising fault-reset bit
  fault_edge_a: assert property (fault_reset_pulse |-> $past(cmd_commit)
    && $past(rx_word[CMD_FRST_BIT]) && !$past(cmd_bits_reg[CMD_FRST_BIT]))
    else $error("fault reset pulse without a rising bit"); // (R4)
  // (R4) no repeated pulse
  fault_single_a: assert property (fault_reset_pulse |=> !fault_reset_pulse)
    else $error("fault reset pulse repeated"); // (R4)
  // (R9) network error flag
  neterr_set_a: assert property (net_error |=> net_error_flag && cmd_readback[15])
    else $error("network error not flagged"); // (R9)
  // (R12) read-only write refusal
  ro_refuse_a: assert property (collect && rx_done && addr_is_ro(addr_reg)
    |=> rsp_valid && rsp_status == RSP_WRITE_REFUSED)
    else $error("read-only write not refused"); // (R12)
  // (R12) run lock on ramps
  ramp_lock_a: assert property (collect && rx_done && ramp_addr && running
    |=> $stable(ramp_up_time) && $stable(ramp_down_time))
    else $error("ramp time changed while running"); // (R12)
  // (R8) reserved frequency source
  fsrc_rsvd_a: assert property (collect && rx_done && addr_reg == ADDR_CMD && fsrc_rsvd
    |=> rsp_status == RSP_BAD_VALUE && $stable(freq_source))
    else $error("reserved frequency source accepted"); // (R8)
  // (R13) four characters per word
  read_chars_a: assert property (read_ok |=> rsp_char_valid[*4] ##1 !rsp_char_valid)
    else $error("read answer not four characters"); // (R13)
  // (R13) high digit first
  first_digit_a: assert property (read_ok
    |=> rsp_char == nib_to_ascii($past(rd_word[15:12])))
    else $error("first character is not the high digit"); // (R13)
  // (R6) unused bits read zero
  unused_zero_a: assert property (cmd_readback[5] == 1'b0 && cmd_readback[14:13] == 2'h0)
    else $error("unused command bits not zero"); // (R6)
  // (R1) unmapped address answer
  bad_addr_a: assert property (read_bad |=> rsp_valid && rsp_status == RSP_BAD_ADDR
    && !rsp_char_valid)
    else $error("unmapped read not answered as bad address"); // (R1)
  // (R10) status flags above bit 5 stay clear
  state_bits_a: assert property (state_word[15:6] == 10'h000)
    else $error("status word has bits above the six flags"); // (R10)

  read_seen_c:   cover property (read_ok ##1 rsp_valid ##4 cmd_ready);
  write_ok_c:    cover property (wr_commit ##1 rsp_status == RSP_OK);
  refused_c:     cover property (rsp_valid && rsp_status == RSP_WRITE_REFUSED);
  fault_pulse_c: cover property (fault_reset_pulse);

endmodule // drive_param_bank
`default_nettype wire

/* tb/link_master_model.sv */
// remote serial master model that issues word reads and writes to the bank
`timescale 1ns/1ps
`default_nettype none
module link_master_model
  import drive_regs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        cmd_ready,
  input  wire logic        rsp_valid,
  input  wire logic [1:0]  rsp_status,
  input  wire logic [7:0]  rsp_char,
  input  wire logic        rsp_char_valid,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [15:0]      cmd_addr,
  output logic [7:0]       wr_char,
  output logic             wr_char_valid
);
  // idle at time zero; released lines show the inverse
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 16'h0000;
    wr_char = 8'h00;
    wr_char_valid = 1'b0;
  end

  // characters to nibbles and back, upper-case hex
  function automatic logic [3:0] char_nib(input logic [7:0] c);
    char_nib = (c >= 8'h41) ? 4'(c - 8'h37) : c[3:0];
  endfunction
  function automatic logic [7:0] nib_char(input logic [3:0] n);
    nib_char = (n > 4'h9) ? (8'h37 + {4'h0, n}) : (8'h30 + {4'h0, n});
  endfunction

  // raise a request at a falling edge once the bank is idle, hold it over the taking edge
  task automatic request(input logic wr, input logic [15:0] addr);
    while (cmd_ready !== 1'b1) @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = addr;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd_addr = ~addr;
  endtask

  // high digit first: shift each answer character in at the bottom
  task automatic read_word(input logic [15:0] addr, output logic [15:0] data,
                           output logic [1:0] st);
    data = 16'h0000;
    st = 2'bxx;
    request(1'b0, addr);
    for (int i = 0; i < 6; i++)
    begin
      if (rsp_valid === 1'b1) st = rsp_status;
      if (rsp_char_valid === 1'b1) data = {data[11:0], char_nib(rsp_char)};
      @(negedge clk_sys);
    end
  endtask

  // four characters, high digit first, then wait a bounded time for the answer
  task automatic write_word(input logic [15:0] addr, input logic [15:0] data,
                            output logic [1:0] st);
    request(1'b1, addr);
    for (int i = 3; i >= 0; i--)
    begin
      wr_char = nib_char(data[4*i +: 4]);
      wr_char_valid = 1'b1;
      @(negedge clk_sys);
    end
    wr_char_valid = 1'b0;
    wr_char = ~wr_char;
    for (int i = 0; i < 8 && rsp_valid !== 1'b1; i++) @(negedge clk_sys);
    st = (rsp_valid === 1'b1) ? rsp_status : 2'bxx;
  endtask
endmodule // link_master_model
`default_nettype wire

/* tb/drive_comm_common_register_map_tb.sv */
// self-checking bench for the drive parameter register bank
`timescale 1ns/1ps
`default_nettype none
module drive_comm_common_register_map_tb;
  import drive_regs_pkg::*;
  logic clk_sys, rstn, cmd_valid, cmd_write, cmd_ready, wr_char_valid, rsp_valid;
  logic rsp_char_valid, fw_load, net_error, stop_cmd, fwd_run_cmd, rev_run_cmd;
  logic fault_reset_pulse, emergency_stop, net_error_flag;
  logic [15:0] cmd_addr, fw_addr, fw_data, target_frequency, ramp_up_time, ramp_down_time;
  logic [7:0]  wr_char, rsp_char;
  logic [1:0]  rsp_status, run_source, st;
  logic [4:0]  freq_source;
  logic [15:0] rd;
  int          fail_count, n_checks, pulses;

  drive_param_bank i_drive_param_bank (.clk_sys(clk_sys), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_ready(cmd_ready), .wr_char(wr_char), .wr_char_valid(wr_char_valid),
    .rsp_valid(rsp_valid), .rsp_status(rsp_status), .rsp_char(rsp_char),
    .rsp_char_valid(rsp_char_valid), .fw_load(fw_load), .fw_addr(fw_addr),
    .fw_data(fw_data), .net_error(net_error), .target_frequency(target_frequency),
    .ramp_up_time(ramp_up_time), .ramp_down_time(ramp_down_time), .stop_cmd(stop_cmd),
    .fwd_run_cmd(fwd_run_cmd), .rev_run_cmd(rev_run_cmd),
    .fault_reset_pulse(fault_reset_pulse), .emergency_stop(emergency_stop),
    .run_source(run_source), .freq_source(freq_source), .net_error_flag(net_error_flag));
  link_master_model i_link_master_model (.clk_sys(clk_sys), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_status(rsp_status), .rsp_char(rsp_char),
    .rsp_char_valid(rsp_char_valid), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .wr_char(wr_char), .wr_char_valid(wr_char_valid));

  // 125 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // a stretched pulse shows as extra counts
  always @(negedge clk_sys)
    if (fault_reset_pulse === 1'b1) pulses++;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input logic [1:0] es);
    i_link_master_model.read_word(a, rd, st);
    check(rd, exp, "read data");
    check({14'h0, st}, {14'h0, es}, "read status");
  endtask

  task automatic wr_chk(input logic [15:0] a, input logic [15:0] d, input logic [1:0] es);
    i_link_master_model.write_word(a, d, st);
    check({14'h0, st}, {14'h0, es}, "write status");
  endtask

  // firmware side load, one-cycle strobe
  task automatic fw(input logic [15:0] a, input logic [15:0] d);
    fw_load = 1'b1;
    fw_addr = a;
    fw_data = d;
    @(negedge clk_sys);
    fw_load = 1'b0;
    @(negedge clk_sys);
  endtask

  // every word clears at reset; the hole at 0x0004 answers bad address
  task automatic t_reset();
    for (int a = 0; a < 15; a++)
      rd_chk(16'(a), 16'h0000, (a == 4) ? RSP_BAD_ADDR : RSP_OK);
    check({15'h0, stop_cmd | fwd_run_cmd | emergency_stop}, 16'h0000, "cmd outs");
    wr_chk(16'h0004, 16'h1234, RSP_BAD_ADDR);
    $display("test reset done");
  endtask

  // read-only identity and measurement words
  task automatic t_ident();
    fw(ADDR_VERSION, 16'h0101);
    rd_chk(ADDR_VERSION, 16'h0101, RSP_OK);
    fw(ADDR_RATING, 16'h0017);
    fw(ADDR_RATING, 16'h0018);
    rd_chk(ADDR_RATING, 16'h0017, RSP_OK);
    fw(ADDR_RATING, 16'h0004);
    rd_chk(ADDR_RATING, 16'h0004, RSP_OK);
    wr_chk(ADDR_VERSION, 16'h0200, RSP_WRITE_REFUSED);
    rd_chk(ADDR_VERSION, 16'h0101, RSP_OK);
    fw(ADDR_OFREQ, 16'h1770);
    rd_chk(ADDR_OFREQ, 16'h1770, RSP_OK);
    $display("test ident done");
  endtask

  // every frequency source and run source code, reserved codes refused
  task automatic t_command();
    logic [4:0] last;
    last = 5'h00;
    for (int i = 0; i < 32; i++)
    begin
      wr_chk(ADDR_CMD, {3'h0, 5'(i), 2'(i), 6'h12}, (i == 20 || i == 21) ? RSP_BAD_VALUE : RSP_OK);
      if (i != 20 && i != 21) last = 5'(i);
      check({11'h0, freq_source}, {11'h0, last}, "freq source");
      check({14'h0, run_source}, {14'h0, 2'(last)}, "run source");
      check({15'h0, fwd_run_cmd & emergency_stop}, 16'h0001, "fwd estop");
    end
    wr_chk(ADDR_CMD, 16'h0025, RSP_OK);
    check({13'h0, rev_run_cmd, fwd_run_cmd, stop_cmd}, 16'h0005, "stop rev");
    rd_chk(ADDR_CMD, 16'h0005, RSP_OK);
    $display("test command done");
  endtask

  // fault reset fires on the rising change only, for exactly one cycle
  task automatic t_fault();
    int p0;
    p0 = pulses;
    wr_chk(ADDR_CMD, 16'h0008, RSP_OK);
    wr_chk(ADDR_CMD, 16'h0008, RSP_OK);
    check(16'(pulses - p0), 16'h0001, "held bit");
    wr_chk(ADDR_CMD, 16'h0000, RSP_OK);
    wr_chk(ADDR_CMD, 16'h0008, RSP_OK);
    @(negedge clk_sys);
    check(16'(pulses - p0), 16'h0002, "second rise");
    $display("test fault done");
  endtask

  // status mask and the run lock on the ramp times
  task automatic t_lock();
    fw(ADDR_STATE, 16'h00FF);
    rd_chk(ADDR_STATE, 16'h003F, RSP_OK);
    wr_chk(ADDR_RUP, 16'h0123, RSP_WRITE_REFUSED);
    check(ramp_up_time, 16'h0000, "locked ramp");
    fw(ADDR_STATE, 16'h0001);
    wr_chk(ADDR_RUP, 16'h0123, RSP_OK);
    check(ramp_up_time, 16'h0123, "ramp up");
    wr_chk(ADDR_RDN, 16'hABCD, RSP_OK);
    rd_chk(ADDR_RDN, 16'hABCD, RSP_OK);
    check(ramp_down_time, 16'hABCD, "ramp down");
    wr_chk(ADDR_TFREQ, 16'h1770, RSP_OK);
    check(target_frequency, 16'h1770, "target freq");
    $display("test lock done");
  endtask

  // network error sets bit 15; a clean command write clears it
  task automatic t_neterr();
    wr_chk(ADDR_CMD, 16'h0000, RSP_OK);
    net_error = 1'b1;
    @(negedge clk_sys);
    net_error = 1'b0;
    @(negedge clk_sys);
    check({15'h0, net_error_flag}, 16'h0001, "net flag");
    rd_chk(ADDR_CMD, 16'h8000, RSP_OK);
    wr_chk(ADDR_CMD, 16'h0000, RSP_OK);
    check({15'h0, net_error_flag}, 16'h0000, "net clear");
    $display("test neterr done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog far past the test length
  initial
  begin
    #200000;
    fail_count++;
    close_out();
  end

  // main sequence; inputs change on falling edges
  initial
  begin
    {rstn, fw_load, net_error, fw_addr, fw_data} = '0;
    fail_count = 0;
    n_checks = 0;
    pulses = 0;
    repeat (5) @(negedge clk_sys);
    rstn = 1'b1;
    t_reset();
    t_ident();
    t_command();
    t_fault();
    t_lock();
    t_neterr();
    close_out();
  end
endmodule // drive_comm_common_register_map_tb
`default_nettype wire
